/* design/pug_guard.sv */
`timescale 1ns/10ps
module pug_guard (
  // Clock, reset and enable
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire logic                  ce,
  // Supply monitor pins
  input  wire logic                  vcc_ok,
  input  wire logic                  vcc_low,
  input  wire logic                  vcc_off,
  // Fitted options
  input  wire logic                  hyst_large,
  input  wire logic                  port_en,
  input  wire logic                  keeper_opt,
  input  wire logic [`PUG_NMC-1:0]   out_pol,
  input  wire logic [`PUG_NMC-1:0]   out_en,
  // Macrocell pins
  input  wire logic                  gclk,
  input  wire logic [`PUG_NMC-1:0]   d_in,
  input  wire logic [`PUG_NMC-1:0]   io_in,
  output wire logic [`PUG_NMC-1:0]   io_out,
  output wire logic [`PUG_NMC-1:0]   io_oe_n,
  output wire logic                  keep_en,
  output wire logic [`PUG_NMC-1:0]   keep_lvl,
  // Test access port pins
  input  wire logic                  tck,
  input  wire logic                  tms,
  input  wire logic                  tdi,
  output wire logic                  tdo,
  output wire logic                  tdo_oe_n,
  output wire logic [2:0]            aux_in,
  // Status
  output wire logic                  por_busy,
  output wire logic                  reinit_bad,
  output wire logic                  in_system_programming,
  output wire logic                  locked,
  output wire logic                  fuse_set,
  output wire pug_pkg::pug_tap_e     tap_state
);
  import pug_pkg::*;

  localparam logic [`PUG_CNT_W-1:0] TD_LAST =
    `PUG_CNT_W'(`PUG_TD_CYC - 1);
  localparam pug_st_s ST_RST = '{
    pwr_dn:   1'b1,
    armed:    1'b1,
    por_act:  1'b1,
    io_oe_n:  16'hFFFF,
    tdo_oe_n: 1'b1,
    ir:       IR_BYPASS,
    tap:      TAP_TLR,
    default:  '0
  };

  pug_st_s st_reg;
  pug_st_s st_next;

  logic                vcc_ok_s;
  logic                vcc_low_s;
  logic                vcc_off_s;
  logic                gclk_s;
  logic                tck_s;
  logic                tms_s;
  logic                tdi_s;
  logic [`PUG_NMC-1:0] io_s;
  logic [`PUG_NMC-1:0] d_s;
  logic                trip;
  logic                tck_rise;
  logic                tck_fall;

  pug_mem_if mem_bus ();

  pug_cfg_mem u_cfg_mem (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .m       (mem_bus.mem)
  );

  function automatic pug_tap_e tap_next(pug_tap_e s, logic m);
    case (s)
      TAP_TLR:    tap_next = m ? TAP_TLR    : TAP_RTI;
      TAP_RTI:    tap_next = m ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_next = m ? TAP_UPD_DR : TAP_PA_DR;
      TAP_PA_DR:  tap_next = m ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: tap_next = m ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_IR: tap_next = m ? TAP_TLR    : TAP_CAP_IR;
      TAP_CAP_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_next = m ? TAP_UPD_IR : TAP_PA_IR;
      TAP_PA_IR:  tap_next = m ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: tap_next = m ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_RTI;
      default:    tap_next = TAP_TLR;
    endcase
  endfunction

  // Every supply, clock, port and macrocell pin is read only after the second synchroniser stage; the fitted options are used directly.
  assign {vcc_ok_s, vcc_low_s, vcc_off_s, gclk_s, tck_s, tms_s, tdi_s,
          io_s, d_s} = st_reg.sy2;

  // Large hysteresis only trips at the lower supply level.
  assign trip     = hyst_large ? vcc_low_s : !vcc_ok_s;
  assign tck_rise = tck_s && !st_reg.tck_d;
  assign tck_fall = !tck_s && st_reg.tck_d;

  always_comb begin
    st_next = st_reg;
    st_next.sy1 = {vcc_ok, vcc_low, vcc_off, gclk, tck, tms, tdi,
                   io_in, d_in};
    st_next.sy2 = st_reg.sy1;
    st_next.gclk_d = gclk_s;
    st_next.tck_d = tck_s;
    st_next.mem_we = 1'b0;

    if (trip) begin
      st_next.pwr_dn = 1'b1;
      if (!hyst_large || vcc_off_s) begin
        st_next.armed = 1'b1;
        st_next.por_act = 1'b1;
        st_next.por_cnt = '0;
      end
    end else if (st_reg.pwr_dn && vcc_ok_s) begin
      if (!st_reg.armed) begin
        // A drop that never reached full off leaves stale registers.
        st_next.reinit_bad = 1'b1;
        st_next.pwr_dn = 1'b0;
      end else if (st_reg.por_cnt == TD_LAST) begin
        st_next.por_act = 1'b0;
        st_next.pwr_dn = 1'b0;
        st_next.armed = 1'b0;
        st_next.reinit_bad = 1'b0;
      end else begin
        st_next.por_cnt = st_reg.por_cnt + `PUG_CNT_W'(1);
      end
    end

    if (st_reg.por_act) begin
      st_next.mc_q = '0;
    end else if (gclk_s && !st_reg.gclk_d) begin
      // Edges inside the reset delay are dropped by the branch above.
      st_next.mc_q = d_s;
    end
    st_next.io_out = st_next.mc_q ^ out_pol;

    st_next.io_oe_n = (st_reg.prog || st_reg.lock) ? '1 : ~out_en;
    st_next.keep_en = keeper_opt;
    st_next.keep_lvl = io_s;

    if (!port_en) begin
      st_next.tap = TAP_TLR;
      st_next.ir = IR_BYPASS;
      st_next.tdo_oe_n = 1'b1;
      st_next.aux_in = {tck_s, tms_s, tdi_s};
    end else begin
      st_next.aux_in = '0;
      if (tck_rise) begin
        st_next.tap = tap_next(st_reg.tap, tms_s);
        case (st_reg.tap)
          TAP_TLR: begin
            st_next.ir = IR_BYPASS;
          end
          TAP_CAP_IR: begin
            st_next.ir_sh = `PUG_IR_CAP;
          end
          TAP_SH_IR: begin
            st_next.ir_sh = {tdi_s, st_reg.ir_sh[`PUG_IR_W-1:1]};
          end
          TAP_UPD_IR: begin
            st_next.ir = pug_ir_e'(st_reg.ir_sh);
            st_next.addr = '0;
            if (st_reg.ir_sh == IR_PROG_EN) begin
              // Entering programming clears the fuse but keeps the stored pattern.
              st_next.prog = 1'b1;
              st_next.fuse = 1'b0;
            end
            if (st_reg.ir_sh == IR_PROG_END && st_reg.prog) begin
              st_next.prog = 1'b0;
              st_next.lock = 1'b0;
            end
          end
          TAP_CAP_DR: begin
            st_next.byp = 1'b0;
            case (st_reg.ir)
              IR_SIG_RD: st_next.dr_sh = st_reg.sig;
              IR_CFG_RD: st_next.dr_sh = st_reg.fuse ? '0 :
                                         mem_bus.rdata;
              default:   st_next.dr_sh = '0;
            endcase
          end
          TAP_SH_DR: begin
            st_next.dr_sh = {tdi_s, st_reg.dr_sh[`PUG_SIG_W-1:1]};
            st_next.byp = tdi_s;
          end
          TAP_UPD_DR: begin
            case (st_reg.ir)
              IR_CFG_WR: begin
                if (st_reg.prog) begin
                  st_next.mem_we = 1'b1;
                  st_next.mem_addr = st_reg.addr;
                  st_next.mem_wdata = st_reg.dr_sh;
                  st_next.addr = st_reg.addr + `PUG_AW'(1);
                end
              end
              IR_CFG_RD: begin
                st_next.addr = st_reg.addr + `PUG_AW'(1);
              end
              IR_SIG_WR: begin
                if (st_reg.prog) begin
                  st_next.sig = st_reg.dr_sh;
                end
              end
              IR_FUSE: begin
                if (st_reg.prog) begin
                  st_next.fuse = 1'b1;
                end
              end
              default: begin
              end
            endcase
          end
          default: begin
          end
        endcase
      end
      if (tck_fall) begin
        if (st_reg.tap == TAP_SH_IR) begin
          st_next.tdo = st_reg.ir_sh[0];
        end else if (st_reg.ir == IR_BYPASS) begin
          st_next.tdo = st_reg.byp;
        end else begin
          st_next.tdo = st_reg.dr_sh[0];
        end
        st_next.tdo_oe_n = !(st_reg.tap == TAP_SH_IR ||
                             st_reg.tap == TAP_SH_DR);
      end
    end

    // Placed last so an abort wins over a normal end in the same cycle.
    if (st_reg.prog && (!port_en || trip || st_next.tap == TAP_TLR)) begin
      st_next.lock = 1'b1;
      st_next.prog = 1'b0;
    end

    // The read port follows the scan address except on a write cycle.
    if (!st_next.mem_we) begin
      st_next.mem_addr = st_next.addr;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_reg <= ST_RST;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign mem_bus.we    = st_reg.mem_we;
  assign mem_bus.addr  = st_reg.mem_addr;
  assign mem_bus.wdata = st_reg.mem_wdata;

  assign io_out                = st_reg.io_out;
  assign io_oe_n               = st_reg.io_oe_n;
  assign keep_en               = st_reg.keep_en;
  assign keep_lvl              = st_reg.keep_lvl;
  assign tdo                   = st_reg.tdo;
  assign tdo_oe_n              = st_reg.tdo_oe_n;
  assign aux_in                = st_reg.aux_in;
  assign por_busy              = st_reg.por_act;
  assign reinit_bad            = st_reg.reinit_bad;
  assign in_system_programming = st_reg.prog;
  assign locked                = st_reg.lock;
  assign fuse_set              = st_reg.fuse;
  assign tap_state             = st_reg.tap;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_por_clears_regs: assert property (
    (ce && st_reg.por_act) |=> (st_reg.mc_q == '0))
    else $error("macrocells not cleared during power-up reset");
  a_por_release_len: assert property (
    $fell(st_reg.por_act) |-> (st_reg.por_cnt == TD_LAST))
    else $error("power-up reset released before the delay");
  a_small_hyst_trip: assert property (
    (ce && !hyst_large && !vcc_ok_s) |=> st_reg.por_act)
    else $error("small hysteresis drop did not reset");
  a_large_no_off: assert property (
    (ce && hyst_large && st_reg.pwr_dn && !st_reg.armed && vcc_ok_s &&
     !vcc_low_s) |=> (st_reg.reinit_bad && !st_reg.por_act))
    else $error("partial drop not flagged");
  a_fuse_blocks_read: assert property (
    (ce && port_en && tck_rise && st_reg.tap == TAP_CAP_DR &&
     st_reg.ir == IR_CFG_RD && st_reg.fuse) |=> (st_reg.dr_sh == '0))
    else $error("pattern read back with fuse set");
  a_sig_always_read: assert property (
    (ce && port_en && tck_rise && st_reg.tap == TAP_CAP_DR &&
     st_reg.ir == IR_SIG_RD) |=> (st_reg.dr_sh == $past(st_reg.sig)))
    else $error("signature not captured");
  a_prog_entry: assert property (
    (ce && port_en && tck_rise && st_reg.tap == TAP_UPD_IR &&
     st_reg.ir_sh == IR_PROG_EN && !trip) |=> (st_reg.prog && !st_reg.fuse))
    else $error("programming entry not taken");
  a_port_disabled: assert property (
    (ce && !port_en) |=> (st_reg.tap == TAP_TLR && st_reg.tdo_oe_n))
    else $error("access port active while disabled");
  a_abort_locks: assert property (
    (ce && st_reg.prog && !port_en) |=> (st_reg.lock && !st_reg.prog))
    else $error("interrupted programming did not lock");
  a_lock_hiz_pins: assert property (
    (ce && st_reg.lock) |=> (st_reg.io_oe_n == '1))
    else $error("pins driven while locked");

  c_por_release: cover property ($fell(st_reg.por_act));
  c_lock_set:    cover property ($rose(st_reg.lock));
  c_prog_end:    cover property ($fell(st_reg.prog) && !st_reg.lock);
endmodule

/* design/pug_defs.svh */
`ifndef PUG_DEFS_SVH
`define PUG_DEFS_SVH
`define PUG_CLK_MHZ 100
`define PUG_TD_NS 1000
`define PUG_TD_CYC ((`PUG_TD_NS * `PUG_CLK_MHZ + 999) / 1000)
`define PUG_CNT_W 8
`define PUG_NMC 16
`define PUG_SIG_W 16
`define PUG_CFG_WORDS 16
`define PUG_AW 4
`define PUG_IR_W 4
`define PUG_IR_CAP 4'h1
`define PUG_SY_W 39
`endif

/* design/pug_pkg.sv */
package pug_pkg;
`include "pug_defs.svh"

  typedef enum logic [3:0] {
    TAP_TLR    = 4'h0,
    TAP_RTI    = 4'h1,
    TAP_SEL_DR = 4'h2,
    TAP_CAP_DR = 4'h3,
    TAP_SH_DR  = 4'h4,
    TAP_EX1_DR = 4'h5,
    TAP_PA_DR  = 4'h6,
    TAP_EX2_DR = 4'h7,
    TAP_UPD_DR = 4'h8,
    TAP_SEL_IR = 4'h9,
    TAP_CAP_IR = 4'hA,
    TAP_SH_IR  = 4'hB,
    TAP_EX1_IR = 4'hC,
    TAP_PA_IR  = 4'hD,
    TAP_EX2_IR = 4'hE,
    TAP_UPD_IR = 4'hF
  } pug_tap_e;

  typedef enum logic [3:0] {
    IR_SIG_RD   = 4'h1,
    IR_CFG_RD   = 4'h2,
    IR_PROG_EN  = 4'h3,
    IR_CFG_WR   = 4'h4,
    IR_SIG_WR   = 4'h5,
    IR_FUSE     = 4'h6,
    IR_PROG_END = 4'h7,
    IR_BYPASS   = 4'hF
  } pug_ir_e;

  typedef struct packed {
    logic [`PUG_SY_W-1:0]  sy1;
    logic [`PUG_SY_W-1:0]  sy2;
    logic                  gclk_d;
    logic                  tck_d;
    logic                  pwr_dn;
    logic                  armed;
    logic                  por_act;
    logic                  reinit_bad;
    logic [`PUG_CNT_W-1:0] por_cnt;
    logic [`PUG_NMC-1:0]   mc_q;
    logic [`PUG_NMC-1:0]   io_out;
    logic [`PUG_NMC-1:0]   io_oe_n;
    logic                  keep_en;
    logic [`PUG_NMC-1:0]   keep_lvl;
    pug_tap_e              tap;
    pug_ir_e               ir;
    logic [`PUG_IR_W-1:0]  ir_sh;
    logic [`PUG_SIG_W-1:0] dr_sh;
    logic                  byp;
    logic [`PUG_AW-1:0]    addr;
    logic                  fuse;
    logic [`PUG_SIG_W-1:0] sig;
    logic                  prog;
    logic                  lock;
    logic                  tdo;
    logic                  tdo_oe_n;
    logic [2:0]            aux_in;
    logic                  mem_we;
    logic [`PUG_AW-1:0]    mem_addr;
    logic [`PUG_SIG_W-1:0] mem_wdata;
  } pug_st_s;

  typedef struct packed {
    logic [`PUG_CFG_WORDS-1:0][`PUG_SIG_W-1:0] words;
    logic [`PUG_SIG_W-1:0]                     rdata;
  } pug_mem_s;
endpackage

/* design/pug_mem_if.sv */
`timescale 1ns/10ps
interface pug_mem_if;
  import pug_pkg::*;
  logic                  we;
  logic [`PUG_AW-1:0]    addr;
  logic [`PUG_SIG_W-1:0] wdata;
  logic [`PUG_SIG_W-1:0] rdata;
  modport ctl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface

/* design/pug_cfg_mem.sv */
`timescale 1ns/10ps
module pug_cfg_mem (
  // Clock, reset and enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Controller side
  pug_mem_if.mem   m
);
  import pug_pkg::*;

  pug_mem_s st_reg;
  pug_mem_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.rdata = st_reg.words[m.addr];
    if (m.we) begin
      st_next.words[m.addr] = m.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign m.rdata = st_reg.rdata;
endmodule

/* tb/pug_prog_model.sv */
`timescale 1ns/10ps
module pug_prog_model (
  // Access port pins
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  // The port clock stands low between frames.
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One port clock; tdo is taken just before the rising edge.
  task automatic tick(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #62;
    q = tdo;
    tck = 1'b1;
    #63;
    tck = 1'b0;
  endtask
  // Five high tms clocks reach the logic reset state, then idle.
  task automatic to_idle();
    logic q;
    repeat (5) tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
  endtask
  // Shifts n bits LSB first through the instruction or data path.
  task automatic scan(input bit ir, input int n, input logic [15:0] din,
                      output logic [15:0] dout);
    logic q;
    dout = '0;
    tick(1'b1, 1'b0, q);
    if (ir) tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
    tick(1'b0, 1'b0, q);
    for (int k = 0; k < n; k++) begin
      tick(k == n - 1, din[k], q);
      dout[k] = q;
    end
    tick(1'b1, 1'b0, q);
    // A released data line must not look as if it still held its bit.
    tick(1'b0, ~din[n - 1], q);
  endtask
  // Static pin levels while the port serves as user pins.
  task automatic levels(input logic t, input logic m, input logic d);
    tck = t;
    tms = m;
    tdi = d;
  endtask
endmodule

/* tb/powerup_reset_isp_guard_bench.sv */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  fail_count++; $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module powerup_reset_isp_guard_bench;
  import pug_pkg::*;
  localparam int TD_CYC = 100;
  logic clk_sys = 0, rst = 1, vcc_ok = 0, vcc_low = 0, vcc_off = 0;
  logic hyst_large = 0, port_en = 1, gclk = 0, ext_drv = 1;
  logic [15:0] d_in = '0, ext_lvl = 16'h00C3, r;
  wire  [15:0] io_in, io_out, io_oe_n, keep_lvl;
  wire         keep_en, tck, tms, tdi, tdo, por_busy, reinit_bad;
  wire         prog_on, locked, fuse_set, tdo_oe_n;
  wire  [2:0]  aux_in;
  pug_tap_e    tap_state;
  int          fail_count = 0, checks_done = 0, n;
  logic [15:0] rows [4][2] = '{'{16'h0000, 16'h0F0F}, '{16'hFFFF, 16'hF0F0},
                               '{16'hA5A5, 16'hAAAA}, '{16'h1234, 16'h1D3B}};
  always #5 clk_sys = ~clk_sys;
  // Wire level: the device, else the far side, else the weak keeper.
  assign io_in = (~io_oe_n & io_out) | (io_oe_n & (ext_drv ? ext_lvl :
                 (keep_en ? keep_lvl : ~ext_lvl)));
  pug_guard u_dut (.clk_sys(clk_sys), .rst(rst), .ce(1'b1),
    .vcc_ok(vcc_ok), .vcc_low(vcc_low), .vcc_off(vcc_off),
    .hyst_large(hyst_large), .port_en(port_en), .keeper_opt(1'b1),
    .out_pol(16'h0F0F), .out_en(16'hFF00), .gclk(gclk), .d_in(d_in),
    .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n), .keep_en(keep_en),
    .keep_lvl(keep_lvl), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe_n(tdo_oe_n), .aux_in(aux_in), .por_busy(por_busy),
    .reinit_bad(reinit_bad), .in_system_programming(prog_on), .locked(locked),
    .fuse_set(fuse_set), .tap_state(tap_state));
  pug_prog_model u_prog (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_por(output int c);
    c = 0;
    while (por_busy !== 1'b0 && c < 400) begin
      cyc(1);
      c++;
    end
  endtask
  task automatic ir(input logic [3:0] code);
    u_prog.scan(1'b1, 4, {12'h000, code}, r);
    `CHK("ir_capture", 4'h1, r[3:0])
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #500000;
    fail_count++;
    close_out();
  end
  initial begin
    cyc(4);
    `CHK("rst_busy", 1'b1, por_busy)
    `CHK("rst_oe", 16'hFFFF, io_oe_n)
    `CHK("rst_lock", 1'b0, locked)
    rst = 0;
    vcc_ok = 1;
    wait_por(n);
    `CHK("por_len", 1'b1, n >= TD_CYC && n <= TD_CYC + 6)
    `CHK("pol_out", 16'h0F0F, io_out)
    `CHK("pol_oe", 16'h00FF, io_oe_n)
    for (int i = 0; i < 4; i++) begin
      d_in = rows[i][0];
      cyc(3);
      gclk = 1;
      cyc(5);
      `CHK("mc_out", rows[i][1], io_out)
      gclk = 0;
      cyc(3);
    end
    // Small trip; a clock edge inside the reset delay is ignored.
    vcc_ok = 0;
    cyc(5);
    `CHK("trip_busy", 1'b1, por_busy)
    `CHK("trip_out", 16'h0F0F, io_out)
    vcc_ok = 1;
    d_in = 16'hFFFF;
    cyc(10);
    gclk = 1;
    cyc(5);
    gclk = 0;
    wait_por(n);
    `CHK("td_ignore", 16'h0F0F, io_out)
    // The port leaves reset in its logic reset state; walk it to idle.
    u_prog.to_idle();
    // A complete run writes word, signature and fuse.
    ir(IR_PROG_EN);
    `CHK("run_on", 1'b1, prog_on)
    ir(IR_CFG_WR);
    u_prog.scan(1'b0, 16, 16'h1234, r);
    ir(IR_SIG_WR);
    u_prog.scan(1'b0, 16, 16'hA5C3, r);
    ir(IR_FUSE);
    u_prog.scan(1'b0, 16, 16'h0000, r);
    ir(IR_PROG_END);
    `CHK("run_off", 1'b0, prog_on)
    `CHK("fuse", 1'b1, fuse_set)
    ir(IR_SIG_RD);
    u_prog.scan(1'b0, 16, 16'h0000, r);
    `CHK("sig_rd", 16'hA5C3, r)
    ir(IR_CFG_RD);
    u_prog.scan(1'b0, 16, 16'h0000, r);
    `CHK("cfg_block", 16'h0000, r)
    `CHK("tap_idle", TAP_RTI, tap_state)
    `CHK("tdo_off", 1'b1, tdo_oe_n)
    // Far side lets go; an aborted run locks and the keepers hold.
    ext_drv = 0;
    ir(IR_PROG_EN);
    u_prog.to_idle();
    cyc(6);
    `CHK("lock", 1'b1, locked)
    `CHK("lock_run", 1'b0, prog_on)
    `CHK("lock_hiz", 16'hFFFF, io_oe_n)
    `CHK("keep", 16'h0FC3, keep_lvl)
    ir(IR_PROG_EN);
    ir(IR_PROG_END);
    cyc(2);
    `CHK("unlock", 1'b0, locked)
    `CHK("unlock_oe", 16'h00FF, io_oe_n)
    // With the fuse erased the stored word reads back again.
    ir(IR_CFG_RD);
    u_prog.scan(1'b0, 16, 16'h0000, r);
    `CHK("cfg_open", 16'h1234, r)
    // Disabling the port in mid-run is an interruption as well.
    ir(IR_PROG_EN);
    port_en = 0;
    cyc(3);
    `CHK("off_lock", 1'b1, locked)
    port_en = 1;
    // Large hysteresis needs a full off before it reinitialises.
    hyst_large = 1;
    rst = 1;
    cyc(4);
    rst = 0;
    wait_por(n);
    vcc_ok = 0;
    cyc(10);
    `CHK("lg_dip", 1'b0, por_busy)
    vcc_low = 1;
    cyc(10);
    // Stale registers only show once the supply comes back.
    vcc_low = 0;
    vcc_ok = 1;
    cyc(10);
    `CHK("lg_bad", 1'b1, reinit_bad)
    `CHK("lg_nobusy", 1'b0, por_busy)
    vcc_ok = 0;
    vcc_low = 1;
    vcc_off = 1;
    cyc(5);
    `CHK("lg_off", 1'b1, por_busy)
    // Port disabled: its pins read as user inputs.
    port_en = 0;
    u_prog.levels(1'b1, 1'b0, 1'b1);
    cyc(5);
    `CHK("aux", 3'b101, aux_in)
    `CHK("aux_tap", TAP_TLR, tap_state)
    close_out();
  end
endmodule
